// *** hdl/ciu_pkg.sv ***
// Purpose: shared constants and types of the cpu interrupt unit
// Assumes: one clock cycle is half a cpu t-state
// Notes:   source codes and option encodings used by ciu_top and the bench
package ciu_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int STACK_DEPTH = 12;
  localparam int PC_W        = 16;
  localparam int FLAG_W      = 4;
  localparam int BANK_W      = 4;
  localparam int VBASE_W     = 8;
  localparam int WAIT_W      = 3;
  localparam int STACK_W     = 1 + FLAG_W + BANK_W + PC_W;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS        = 5000;
  localparam int CLKS_PER_TSTATE      = 2;
  localparam int REMOTE_DELAY_TSTATES = 2;
  localparam int REMOTE_DELAY_CLKS    = REMOTE_DELAY_TSTATES * CLKS_PER_TSTATE;

  // ****************************************
  // mask bit positions and reset values
  // ****************************************
  localparam int MASK_RX     = 0;
  localparam int MASK_TX     = 1;
  localparam int MASK_TURN   = 2;
  localparam int MASK_REMOTE = 3;
  localparam int MASK_TO     = 4;
  localparam logic [4:0] MASK_RESET = 5'h1f;
  localparam logic       GIE_RESET  = 1'b0;

  // ****************************************
  // vector source codes
  // ****************************************
  localparam logic [2:0] CODE_NMI    = 3'h7;
  localparam logic [2:0] CODE_RX     = 3'h1;
  localparam logic [2:0] CODE_TX     = 3'h2;
  localparam logic [2:0] CODE_TURN   = 3'h3;
  localparam logic [2:0] CODE_REMOTE = 3'h4;
  localparam logic [2:0] CODE_TO     = 3'h5;
  localparam logic [2:0] VEC_MID_PAD = 3'h0;
  localparam logic [1:0] VEC_LOW_PAD = 2'h0;

  // ****************************************
  // receiver select and enable options
  // ****************************************
  localparam logic [1:0] RXSEL_FULL   = 2'h0;
  localparam logic [1:0] RXSEL_BYTE   = 2'h1;
  localparam logic [1:0] RXSEL_ACTIVE = 2'h2;
  localparam logic [1:0] GIE_KEEP     = 2'h0;
  localparam logic [1:0] GIE_CLEAR    = 2'h1;
  localparam logic [1:0] GIE_SET      = 2'h2;
  localparam logic [1:0] GIE_RESTORE  = 2'h3;

  typedef enum logic [2:0] {
    CALL_IDLE = 3'h0,
    CALL_T1A  = 3'h1,
    CALL_T1B  = 3'h3,
    CALL_WAIT = 3'h2,
    CALL_T2A  = 3'h6,
    CALL_T2B  = 3'h7
  } ciu_call_type;

endpackage : ciu_pkg

// *** hdl/ciu_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ciu_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  if (W < 1) begin : g_chk
    $error("ciu_sync width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } ciu_sync_type;

  ciu_sync_type s;
  ciu_sync_type next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  // pins idle high, so the chain resets high to avoid a false edge
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;

endmodule : ciu_sync

// *** hdl/ciu_stack.sv ***
// Purpose: return address stack of saved call state
// Assumes: push and pop never arrive in the same cycle
// Notes:   push when full is dropped; pop when empty reads zero
`timescale 1ns/1ps
module ciu_stack #(
  parameter int DEPTH = ciu_pkg::STACK_DEPTH,
  parameter int W     = ciu_pkg::STACK_W
) (
  input  wire logic         sys_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         push_in,
  input  wire logic         pop_in,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] top_out,
  output logic              full_out,
  output logic              empty_out
);
  if (DEPTH < 2 || DEPTH > 15) begin : g_chk
    $error("ciu_stack depth must be 2 to 15");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [3:0]              count;
    logic                    full;
  } ciu_stack_type;

  ciu_stack_type s;
  ciu_stack_type next_s;

  always_comb begin
    next_s = s;
    if (push_in && !full_out) begin
      next_s.mem[s.count] = data_in;
      next_s.count        = s.count + 4'h1;
    end else if (pop_in && !empty_out) begin
      next_s.count = s.count - 4'h1;
    end
    // full is registered so the flag leaves the unit straight from a flop
    next_s.full = (next_s.count == 4'(DEPTH));
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign full_out  = s.full;
  assign empty_out = (s.count == 4'h0);
  assign top_out   = empty_out ? '0 : s.mem[s.count - 4'h1];

endmodule : ciu_stack

// *** hdl/ciu_top.sv ***
// Purpose: interrupt unit of an 8-bit communications cpu
// Assumes: one clock is half a t-state; control strobes come from same-clock cpu logic
// Notes:   decision is taken on the sample marked by instr_boundary_in
`timescale 1ns/1ps
module ciu_top (
  input  wire logic                         sys_clk_in,
  input  wire logic                         nrst_in,
  input  wire logic                         nmi_n_in,
  input  wire logic                         remote_irq_pin_in,
  output logic                              remote_irq_pin_out,
  output logic                              remote_irq_pin_oe_out,
  input  wire logic                         remote_line_direction_sel_in,
  input  wire logic                         remote_ack_write_in,
  input  wire logic                         irq_control_wr_in,
  input  wire logic [4:0]                   irq_control_mask_in,
  input  wire logic                         rx_select_hi_in,
  input  wire logic                         rx_select_lo_in,
  input  wire logic                         rx_fifo_full_source_in,
  input  wire logic                         rx_byte_ready_source_in,
  input  wire logic                         rx_active_source_in,
  input  wire logic                         tx_fifo_empty_irq_in,
  input  wire logic                         line_turnaround_irq_in,
  input  wire logic                         timeout_irq_in,
  input  wire logic                         gie_wr_in,
  input  wire logic                         gie_data_in,
  input  wire logic                         bank_swap_op_in,
  input  wire logic                         subroutine_exit_op_in,
  input  wire logic                         fast_subroutine_exit_op_in,
  input  wire logic [1:0]                   gie_option_in,
  input  wire logic [ciu_pkg::VBASE_W-1:0]  vector_base_reg_in,
  input  wire logic [ciu_pkg::WAIT_W-1:0]   wait_config_reg_in,
  input  wire logic                         instr_boundary_in,
  input  wire logic                         instr_start_in,
  input  wire logic [ciu_pkg::PC_W-1:0]     next_pc_in,
  input  wire logic [ciu_pkg::FLAG_W-1:0]   alu_flags_in,
  input  wire logic [ciu_pkg::BANK_W-1:0]   bank_pos_in,
  output logic                              global_irq_enable_out,
  output logic                              rx_source_mask_out,
  output logic                              tx_empty_mask_out,
  output logic                              turnaround_mask_out,
  output logic                              remote_line_mask_out,
  output logic                              timeout_mask_out,
  output logic                              remote_ack_status_bit_out,
  output logic                              remote_pin_mirror_bit_out,
  output logic                              suppress_instr_out,
  output logic                              irq_call_out,
  output logic                              call_done_out,
  output logic [ciu_pkg::PC_W-1:0]          vector_out,
  output logic [ciu_pkg::PC_W-1:0]          return_pc_out,
  output logic [ciu_pkg::FLAG_W-1:0]        return_flags_out,
  output logic [ciu_pkg::BANK_W-1:0]        return_bank_out,
  output logic                              return_valid_out,
  output logic                              stack_full_out
);
  localparam int ND = ciu_pkg::REMOTE_DELAY_CLKS;

  typedef struct packed {
    ciu_pkg::ciu_call_type            call;
    logic [3:0]                       wait_cnt;
    logic                             global_irq_enable;
    logic [4:0]                       mask;
    logic [ND-1:0]                    pin_line;
    logic                             pin_oe;
    logic                             mirror;
    logic                             nmi_prev;
    logic                             nmi_pend;
    logic                             suppress;
    logic                             call_done;
    logic [2:0]                       code;
    logic [ciu_pkg::PC_W-1:0]         vector;
    logic [ciu_pkg::PC_W-1:0]         ret_pc;
    logic [ciu_pkg::FLAG_W-1:0]       ret_flags;
    logic [ciu_pkg::BANK_W-1:0]       ret_bank;
    logic                             ret_valid;
  } ciu_top_state_type;

  ciu_top_state_type s;
  ciu_top_state_type next_s;

  // ****************************************
  // pins, stack
  // ****************************************
  logic [1:0]                  pin_sync;
  logic                        nmi_sync;
  logic                        remote_sync;
  logic                        push;
  logic                        pop;
  logic                        stack_full;
  logic [ciu_pkg::STACK_W-1:0] stack_top;

  ciu_sync #(.W(2)) u_sync (
    .sys_clk_in     (sys_clk_in),
    .nrst_in        (nrst_in),
    .async_in       ({nmi_n_in, remote_irq_pin_in}),
    .sync_out       (pin_sync)
  );
  assign nmi_sync    = pin_sync[1];
  assign remote_sync = pin_sync[0];

  ciu_stack #(.DEPTH(ciu_pkg::STACK_DEPTH), .W(ciu_pkg::STACK_W)) u_stack (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .push_in    (push),
    .pop_in     (pop),
    .data_in    ({s.global_irq_enable, alu_flags_in, bank_pos_in, next_pc_in}),
    .top_out    (stack_top),
    .full_out   (stack_full),
    .empty_out  ()
  );

  // ****************************************
  // request selection
  // ****************************************
  logic       rx_src;
  logic       remote_src;
  logic [5:0] req;
  logic       recognize;
  logic [2:0] win_code;

  always_comb begin
    rx_src = 1'b0;
    case ({rx_select_hi_in, rx_select_lo_in})
      ciu_pkg::RXSEL_FULL:   rx_src = rx_fifo_full_source_in;
      ciu_pkg::RXSEL_BYTE:   rx_src = rx_byte_ready_source_in;
      ciu_pkg::RXSEL_ACTIVE: rx_src = rx_active_source_in;
      default:               rx_src = 1'b0;
    endcase
    // remote level only counts as a request in input mode
    remote_src = !remote_line_direction_sel_in && !remote_sync;
    // and by global enable, except nmi
    // one in a mask blocks its source
    // held request is simply seen again once unmasked
    req[0] = s.nmi_pend;
    req[1] = s.global_irq_enable && rx_src && !s.mask[ciu_pkg::MASK_RX];
    req[2] = s.global_irq_enable && tx_fifo_empty_irq_in && !s.mask[ciu_pkg::MASK_TX];
    req[3] = s.global_irq_enable && line_turnaround_irq_in && !s.mask[ciu_pkg::MASK_TURN];
    req[4] = s.global_irq_enable && remote_src && !s.mask[ciu_pkg::MASK_REMOTE];
    req[5] = s.global_irq_enable && timeout_irq_in && !s.mask[ciu_pkg::MASK_TO];
    if (req[0]) begin
      win_code = ciu_pkg::CODE_NMI;
    end else if (req[1]) begin
      win_code = ciu_pkg::CODE_RX;
    end else if (req[2]) begin
      win_code = ciu_pkg::CODE_TX;
    end else if (req[3]) begin
      win_code = ciu_pkg::CODE_TURN;
    end else if (req[4]) begin
      win_code = ciu_pkg::CODE_REMOTE;
    end else begin
      win_code = ciu_pkg::CODE_TO;
    end
    recognize = (s.call == ciu_pkg::CALL_IDLE) && instr_boundary_in && (|req);
    push      = recognize;
    pop       = (s.call == ciu_pkg::CALL_IDLE) && !recognize
                && (subroutine_exit_op_in || fast_subroutine_exit_op_in);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s           = s;
    next_s.call_done = 1'b0;
    next_s.nmi_prev  = nmi_sync;
    next_s.pin_oe    = remote_line_direction_sel_in;
    // pin level follows the remote mask
    next_s.pin_line  = {s.pin_line[ND-2:0], s.mask[ciu_pkg::MASK_REMOTE]};
    // mirror sampled at the start of each instruction
    if (instr_start_in) begin
      next_s.mirror = remote_sync;
    end
    // remote acknowledge toggles; a cpu write in the same cycle wins
    if (remote_line_direction_sel_in && remote_ack_write_in) begin
      next_s.mask[ciu_pkg::MASK_REMOTE] = !s.mask[ciu_pkg::MASK_REMOTE];
    end
    if (irq_control_wr_in) begin
      next_s.mask = irq_control_mask_in;
    end
    if (gie_wr_in) begin
      next_s.global_irq_enable = gie_data_in;
    end
    if (bank_swap_op_in && gie_option_in == ciu_pkg::GIE_CLEAR) begin
      next_s.global_irq_enable = 1'b0;
    end else if (bank_swap_op_in && gie_option_in == ciu_pkg::GIE_SET) begin
      next_s.global_irq_enable = 1'b1;
    end
    // exit ops pop and may restore the enable
    next_s.ret_valid = pop;
    if (pop) begin
      {next_s.ret_flags, next_s.ret_bank, next_s.ret_pc} = stack_top[ciu_pkg::STACK_W-2:0];
      case (gie_option_in)
        ciu_pkg::GIE_CLEAR:   next_s.global_irq_enable = 1'b0;
        ciu_pkg::GIE_SET:     next_s.global_irq_enable = 1'b1;
        ciu_pkg::GIE_RESTORE: next_s.global_irq_enable = stack_top[ciu_pkg::STACK_W-1];
        default:              next_s.global_irq_enable = next_s.global_irq_enable;
      endcase
    end
    // clear on recognition, but a new edge in that cycle wins
    if (recognize && win_code == ciu_pkg::CODE_NMI) begin
      next_s.nmi_pend = 1'b0;
    end
    if (s.nmi_prev && !nmi_sync) begin
      next_s.nmi_pend = 1'b1;
    end
    case (s.call)
      ciu_pkg::CALL_IDLE: begin
        // suppress next instruction, state pushed by the stack
        if (recognize) begin
          next_s.call     = ciu_pkg::CALL_T1A;
          next_s.suppress = 1'b1;
          next_s.code     = win_code;
          next_s.vector   = {vector_base_reg_in, ciu_pkg::VEC_MID_PAD, win_code, ciu_pkg::VEC_LOW_PAD};
        end
      end
      ciu_pkg::CALL_T1A: begin
        // at the end of the first half of T1
        next_s.global_irq_enable  = 1'b0;
        next_s.call = ciu_pkg::CALL_T1B;
      end
      ciu_pkg::CALL_T1B: begin
        // wait states, counted in half t-states
        if (wait_config_reg_in != '0) begin
          next_s.call     = ciu_pkg::CALL_WAIT;
          next_s.wait_cnt = 4'({wait_config_reg_in, 1'b0} - 4'h1);
        end else begin
          next_s.call = ciu_pkg::CALL_T2A;
        end
      end
      ciu_pkg::CALL_WAIT: begin
        if (s.wait_cnt == 4'h0) begin
          next_s.call = ciu_pkg::CALL_T2A;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 4'h1;
        end
      end
      ciu_pkg::CALL_T2A: begin
        next_s.call = ciu_pkg::CALL_T2B;
      end
      ciu_pkg::CALL_T2B: begin
        next_s.call      = ciu_pkg::CALL_IDLE;
        next_s.suppress  = 1'b0;
        next_s.call_done = 1'b1;
      end
      default: begin
        next_s.call     = ciu_pkg::CALL_IDLE;
        next_s.suppress = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s          <= '0;
      s.global_irq_enable      <= ciu_pkg::GIE_RESET;
      s.mask     <= ciu_pkg::MASK_RESET;
      s.pin_line <= '1;
      s.mirror   <= 1'b1;
      s.nmi_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign remote_irq_pin_out        = s.pin_line[ND-1];
  assign remote_irq_pin_oe_out     = s.pin_oe;
  assign global_irq_enable_out     = s.global_irq_enable;
  assign rx_source_mask_out        = s.mask[ciu_pkg::MASK_RX];
  assign tx_empty_mask_out         = s.mask[ciu_pkg::MASK_TX];
  assign turnaround_mask_out       = s.mask[ciu_pkg::MASK_TURN];
  assign remote_line_mask_out      = s.mask[ciu_pkg::MASK_REMOTE];
  assign timeout_mask_out          = s.mask[ciu_pkg::MASK_TO];
  assign remote_ack_status_bit_out = s.mask[ciu_pkg::MASK_REMOTE];
  assign remote_pin_mirror_bit_out = s.mirror;
  assign suppress_instr_out        = s.suppress;
  assign irq_call_out              = s.suppress;
  assign call_done_out             = s.call_done;
  assign vector_out                = s.vector;
  assign return_pc_out             = s.ret_pc;
  assign return_flags_out          = s.ret_flags;
  assign return_bank_out           = s.ret_bank;
  assign return_valid_out          = s.ret_valid;
  assign stack_full_out            = stack_full;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_gie_drop_call: assert property ((s.call == ciu_pkg::CALL_T1A) |=> !s.global_irq_enable)
    else $error("enable not cleared in call");
  a_vector_shape: assert property (recognize |=> s.vector ==
      {$past(vector_base_reg_in), 3'h0, $past(win_code), 2'h0})
    else $error("vector malformed");
  a_nmi_first: assert property ((recognize && s.nmi_pend) |=> s.code == 3'h7)
    else $error("nmi lost priority");
  a_gie_gates: assert property ((recognize && !s.global_irq_enable) |-> s.nmi_pend)
    else $error("maskable taken while disabled");
  a_call_short: assert property ((s.call == ciu_pkg::CALL_T1B && wait_config_reg_in == '0)
      |=> s.call == ciu_pkg::CALL_T2A ##1 s.call == ciu_pkg::CALL_T2B ##1 s.call_done)
    else $error("call length wrong");
  a_wait_enter: assert property ((s.call == ciu_pkg::CALL_T1B && wait_config_reg_in == 3'h1)
      |=> (s.call == ciu_pkg::CALL_WAIT) [*2] ##1 s.call == ciu_pkg::CALL_T2A)
    else $error("wait states wrong");
  a_pin_delay: assert property (remote_irq_pin_out == $past(s.mask[3], 4))
    else $error("pin delay wrong");
  a_ack_toggle: assert property ((remote_line_direction_sel_in && remote_ack_write_in
      && !irq_control_wr_in) |=> s.mask[3] != $past(s.mask[3]))
    else $error("acknowledge did not toggle");
  a_nmi_clear: assert property ((recognize && win_code == 3'h7 && !(s.nmi_prev && !nmi_sync))
      |=> !s.nmi_pend)
    else $error("nmi not cleared");
  a_rx_masked: assert property ((recognize && win_code == 3'h1) |-> !s.mask[0] && s.global_irq_enable)
    else $error("masked receiver taken");

  c_nmi_call: cover property (recognize && win_code == 3'h7);
  c_remote_call: cover property (recognize && win_code == 3'h4);
  c_wait_call: cover property (s.call == ciu_pkg::CALL_WAIT);
  c_restore: cover property (pop && gie_option_in == ciu_pkg::GIE_RESTORE);

endmodule : ciu_top

// *** tb/ciu_remote_host.sv ***
// Purpose: remote host model on the shared interrupt line
// Assumes: the line has a pull-up; the host acks by a one-cycle status write
// Notes:   line level resolves device drive, host drive and pull-up
`timescale 1ns/1ps
module ciu_remote_host (
  input  wire logic sys_clk_in,
  input  wire logic hold_low_in,
  input  wire logic ack_req_in,
  input  wire logic dev_oe_in,
  input  wire logic dev_level_in,
  output logic      line_out,
  output logic      ack_write_out
);
  // host holds low until released, pull-up after
  assign line_out = dev_oe_in ? dev_level_in : !hold_low_in;
  // ack is a write of one
  always_ff @(posedge sys_clk_in) ack_write_out <= ack_req_in;
endmodule : ciu_remote_host

// *** tb/cpu_interrupt_unit_test.sv ***
// Purpose: self-checking bench of the cpu interrupt unit
// Assumes: inputs change by nba at the rising edge, outputs read 1 ns later
// Notes:   the remote host model drives the shared interrupt line
`timescale 1ns/1ps
module cpu_interrupt_unit_test;
  logic        sys_clk_in, nrst_in, nmi_n_in, remote_irq_pin_in, remote_irq_pin_out, remote_irq_pin_oe_out;
  logic        remote_line_direction_sel_in, remote_ack_write_in, irq_control_wr_in, rx_select_hi_in, rx_select_lo_in;
  logic        rx_fifo_full_source_in, rx_byte_ready_source_in, rx_active_source_in, tx_fifo_empty_irq_in;
  logic        line_turnaround_irq_in, timeout_irq_in, gie_wr_in, gie_data_in, bank_swap_op_in, subroutine_exit_op_in;
  logic        fast_subroutine_exit_op_in, instr_boundary_in, instr_start_in, global_irq_enable_out, rx_source_mask_out;
  logic        tx_empty_mask_out, turnaround_mask_out, remote_line_mask_out, timeout_mask_out, remote_ack_status_bit_out;
  logic        remote_pin_mirror_bit_out, suppress_instr_out, irq_call_out, call_done_out, return_valid_out, stack_full_out;
  logic        host_low, host_ack;
  logic [4:0]  irq_control_mask_in;
  logic [1:0]  gie_option_in;
  logic [7:0]  vector_base_reg_in;
  logic [2:0]  wait_config_reg_in;
  logic [15:0] next_pc_in, vector_out, return_pc_out;
  logic [3:0]  alu_flags_in, bank_pos_in, return_flags_out, return_bank_out;
  int          bad_count, comparisons, n;
  localparam logic [2:0] CODES [5] = '{ciu_pkg::CODE_RX, ciu_pkg::CODE_TX, ciu_pkg::CODE_TURN, ciu_pkg::CODE_REMOTE,
                                       ciu_pkg::CODE_TO};

  ciu_top uut (.*);
  ciu_remote_host host (.sys_clk_in(sys_clk_in), .hold_low_in(host_low), .ack_req_in(host_ack),
    .dev_oe_in(remote_irq_pin_oe_out), .dev_level_in(remote_irq_pin_out), .line_out(remote_irq_pin_in),
    .ack_write_out(remote_ack_write_in));

  always #2.5 sys_clk_in = ~sys_clk_in;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic pulse_boundary();
    @(posedge sys_clk_in) instr_boundary_in <= 1'b1;
    @(posedge sys_clk_in) instr_boundary_in <= 1'b0;
    #1;
  endtask : pulse_boundary
  task automatic no_call();
    pulse_boundary();
    tick(3);
    chk(16'(irq_call_out), 16'h0, "call taken");
  endtask : no_call
  task automatic srcs(input logic [4:0] v);
    @(posedge sys_clk_in)
      {rx_byte_ready_source_in, tx_fifo_empty_irq_in, line_turnaround_irq_in, host_low, timeout_irq_in} <= v;
    tick(3);
  endtask : srcs
  task automatic setgie(input logic by_swap);
    @(posedge sys_clk_in) begin
      {next_pc_in, alu_flags_in, bank_pos_in} <= {next_pc_in, alu_flags_in, bank_pos_in} + 24'h111;
      gie_wr_in <= !by_swap;
      gie_data_in <= 1'b1;
      bank_swap_op_in <= by_swap;
      gie_option_in <= ciu_pkg::GIE_SET;
    end
    @(posedge sys_clk_in) {gie_wr_in, bank_swap_op_in} <= 2'h0;
    tick(1);
    chk(16'(global_irq_enable_out), 16'h1, "enable not set");
  endtask : setgie
  task automatic recog(input logic [2:0] code);
    pulse_boundary();
    for (n = 0; irq_call_out !== 1'b1 && n < 4; n++) tick(1);
    chk(vector_out, {vector_base_reg_in, 3'h0, code, 2'h0}, "vector");
    chk(16'(suppress_instr_out), 16'h1, "suppress");
    for (n = 0; irq_call_out === 1'b1 && n < 40; n++) tick(1);
    chk(16'(n), 16'(4 + 2 * wait_config_reg_in), "call length");
    chk(16'(call_done_out), 16'h1, "call done");
    chk(16'(global_irq_enable_out), 16'h0, "enable kept");
  endtask : recog
  task automatic mirror(input logic exp);
    @(posedge sys_clk_in) instr_start_in <= 1'b1;
    @(posedge sys_clk_in) instr_start_in <= 1'b0;
    tick(1);
    chk(16'(remote_pin_mirror_bit_out), 16'(exp), "mirror");
  endtask : mirror
  task automatic pop_chk(input logic fast, input logic [3:0] v, input logic global_irq_enable);
    @(posedge sys_clk_in) begin
      subroutine_exit_op_in <= !fast;
      fast_subroutine_exit_op_in <= fast;
      gie_option_in <= ciu_pkg::GIE_RESTORE;
    end
    @(posedge sys_clk_in) {subroutine_exit_op_in, fast_subroutine_exit_op_in} <= 2'h0;
    #1;
    chk(16'({return_valid_out, return_flags_out, return_bank_out}), 16'({1'b1, v, v}), "pop state");
    chk(return_pc_out, 16'(v), "pop address");
    chk(16'({stack_full_out, global_irq_enable_out}), 16'({1'b0, global_irq_enable}), "pop enable");
  endtask : pop_chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    chk(16'(global_irq_enable_out), 16'h0, "enable at reset");
    chk(16'({timeout_mask_out, remote_line_mask_out, turnaround_mask_out, tx_empty_mask_out, rx_source_mask_out}),
        16'h1f, "masks at reset");
    $display("reset test done");
  endtask : test_reset
  task automatic test_masked();
    srcs(5'h08);
    no_call();
    setgie(1'b0);
    no_call();
    @(posedge sys_clk_in) {irq_control_wr_in, irq_control_mask_in} <= 6'h20;
    @(posedge sys_clk_in) irq_control_wr_in <= 1'b0;
    recog(ciu_pkg::CODE_TX);
    $display("masking test done");
  endtask : test_masked
  task automatic test_priority();
    @(posedge sys_clk_in) {rx_select_lo_in, wait_config_reg_in} <= 4'h9;
    srcs(5'h1f);
    for (int i = 0; i < 5; i++) begin
      setgie(i[0]);
      recog(CODES[i]);
      srcs(5'(5'h1f >> (i + 1)));
    end
    $display("priority test done");
  endtask : test_priority
  task automatic test_nmi();
    @(posedge sys_clk_in) nmi_n_in <= 1'b0;
    tick(4);
    recog(ciu_pkg::CODE_NMI);
    @(posedge sys_clk_in) nmi_n_in <= 1'b1;
    no_call();
    $display("nmi test done");
  endtask : test_nmi
  task automatic test_exit();
    setgie(1'b0);
    pop_chk(1'b0, 4'h6, 1'b0);
    pop_chk(1'b1, 4'h6, 1'b1);
    pop_chk(1'b0, 4'h5, 1'b1);
    $display("exit test done");
  endtask : test_exit
  task automatic test_output();
    @(posedge sys_clk_in) remote_line_direction_sel_in <= 1'b1;
    tick(2);
    chk(16'({remote_irq_pin_oe_out, remote_irq_pin_out}), 16'h2, "pin drive");
    mirror(1'b0);
    @(posedge sys_clk_in) host_ack <= 1'b1;
    @(posedge sys_clk_in) host_ack <= 1'b0;
    for (n = 0; remote_ack_status_bit_out !== 1'b1 && n < 6; n++) tick(1);
    chk(16'({remote_ack_status_bit_out, remote_line_mask_out}), 16'h3, "ack toggle");
    for (n = 0; remote_irq_pin_out !== 1'b1 && n < 10; n++) tick(1);
    chk(16'(n), 16'(ciu_pkg::REMOTE_DELAY_CLKS), "pin delay");
    tick(3);
    mirror(1'b1);
    $display("output mode test done");
  endtask : test_output

  initial begin
    #20000;
    bad_count++;
    stop_test();
  end

  initial begin
    sys_clk_in = 1'b0;
    {nrst_in, remote_line_direction_sel_in, irq_control_wr_in, rx_select_hi_in, rx_select_lo_in, host_low, host_ack,
     rx_fifo_full_source_in, rx_byte_ready_source_in, rx_active_source_in, tx_fifo_empty_irq_in, line_turnaround_irq_in,
     timeout_irq_in, gie_wr_in, gie_data_in, bank_swap_op_in, subroutine_exit_op_in, fast_subroutine_exit_op_in,
     instr_boundary_in, instr_start_in, irq_control_mask_in, gie_option_in, wait_config_reg_in, next_pc_in,
     alu_flags_in, bank_pos_in} = '0;
    nmi_n_in = 1'b1;
    vector_base_reg_in = 8'ha5;
    repeat (12) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    tick(1);
    test_reset();
    test_masked();
    test_priority();
    test_nmi();
    test_exit();
    test_output();
    stop_test();
  end
endmodule : cpu_interrupt_unit_test
